/* rtl/mdfs_map.svh */
// Register offsets, field positions, reset values and timing counts of the fault supervisor
`ifndef MDFS_MAP_SVH
`define MDFS_MAP_SVH
// Register byte offsets
`define MDFS_CTRL_OFS 12'h000
`define MDFS_STAT_OFS 12'h004
// Control register fields
`define MDFS_CTRL_OPEN_EN 0
`define MDFS_CTRL_OPEN_MODE 1
`define MDFS_CTRL_WARN_REP 2
`define MDFS_CTRL_TSD_MODE 3
`define MDFS_CTRL_OUT_EN 4
`define MDFS_CTRL_CLR 5
`define MDFS_CTRL_RST 5'h00
// Status register fields
`define MDFS_ST_ERR 0
`define MDFS_ST_OPEN 1
`define MDFS_ST_OLA 2
`define MDFS_ST_OLB 3
`define MDFS_ST_WARN 4
`define MDFS_ST_THERM 5
`define MDFS_ST_SDOWN 6
`define MDFS_ST_SLEEP 7
// Timing in ns and clock
`define MDFS_CLK_NS 4
`define MDFS_OPEN_TIME_NS 10000
`define MDFS_SLEEP_TIME_NS 120000
`define MDFS_PULSE_MIN_NS 20000
`define MDFS_PULSE_MAX_NS 40000
`define MDFS_OPEN_CYC (`MDFS_OPEN_TIME_NS / `MDFS_CLK_NS)
`define MDFS_SLEEP_CYC (`MDFS_SLEEP_TIME_NS / `MDFS_CLK_NS)
`define MDFS_PMIN_CYC ((`MDFS_PULSE_MIN_NS + `MDFS_CLK_NS - 1) / `MDFS_CLK_NS)
`define MDFS_PMAX_CYC (`MDFS_PULSE_MAX_NS / `MDFS_CLK_NS)
`endif

/* rtl/mdfs_pkg.sv */
// Types of the motor driver fault supervisor
package mdfs_pkg;
  typedef logic [31:0] mdfs_word_t;
  typedef logic [16:0] mdfs_cnt_t;
  typedef enum logic [1:0] {
    MDFS_AWAKE = 2'b00,
    MDFS_DOZE = 2'b01,
    MDFS_ASLEEP = 2'b11
  } mdfs_pwr_e;
endpackage

/* rtl/mdfs_supervisor.sv */
// Fault supervision, output gating and sleep sequencing of a stepper driver
//
// Notes on behaviour
// R1 - Open load when winding current below both thresholds longer than detect time; the code flags either winding on its own
// R2 - Open-load detection works only while open_load_enable is 1
// R3 - Open load latches open flag and error flag and pulls alarm low
// R4 - Separate open flags name winding A and winding B
// R5 - Release mode 1 frees alarm on removal; mode 0 also needs clear
// R6 - Latched open load also clears on reset or leaving sleep
// R7 - Warning sets warn and thermal flags; driving and pump continue
// R8 - Warn and thermal flags from warning clear by themselves on cooling
// R9 - With warn_report_enable the warning also pulls alarm and error flag
// R10 - Shutdown kills bridge and pump, pulls alarm, latches error, thermal, shutdown
// R11 - Recovery mode 0 resumes only after sleep reset pulse or reset
// R12 - Recovery mode 1 resumes on cooling; flags stay until clear
// R13 - Sleep pin low puts bridge, regulator, pump and interface to sleep
// R14 - Sleep entered after sleep delay from falling edge; wake on high
// R15 - Enable pin low holds bridge outputs high impedance
// R16 - Bridge enabled only when sleep pin, enable pin and bit all 1
// R17 - Low pulse of 20 to 40 us on sleep pin clears latched faults
// R18 - Open-drain alarm pulled low while any reported fault active; the code releases it while asleep
// R19 - Analog comparator outputs synchronised before use
`timescale 1ns/1ns
`default_nettype none
`include "mdfs_map.svh"
module mdfs_supervisor
  import mdfs_pkg::*;
#(
  parameter int unsigned OPEN_CYC = `MDFS_OPEN_CYC,
  parameter int unsigned SLEEP_CYC = `MDFS_SLEEP_CYC,
  parameter int unsigned PMIN_CYC = `MDFS_PMIN_CYC,
  parameter int unsigned PMAX_CYC = `MDFS_PMAX_CYC
)
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire mdfs_pkg::mdfs_word_t i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output mdfs_pkg::mdfs_word_t o_prdata,
  // Controller pins
  input wire logic i_low_power_request_n,
  input wire logic i_enable,
  // Analog comparators
  input wire logic i_wind_a_low,
  input wire logic i_wind_b_low,
  input wire logic i_warn_temperature,
  input wire logic i_shutdown_temperature,
  // Power stage controls
  output logic o_bridge_enable,
  output logic o_charge_pump_enable,
  output logic o_logic_regulator_enable,
  output logic o_serial_enable,
  // Open-drain alarm
  output logic o_alarm_out_n,
  output logic o_alarm_out_n_oe
);
  import mdfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers for pins and comparators
  localparam int NS = 6;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  logic [NS-1:0] filt_q;
  assign raw = {i_low_power_request_n, i_enable, i_wind_a_low, i_wind_b_low,
                i_warn_temperature, i_shutdown_temperature};
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      s1_q <= 6'h20;
      s2_q <= 6'h20;
      s3_q <= 6'h20;
      filt_q <= 6'h20;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q)); // [R19]
    end
  end
  logic slp_n, en_pin, low_a, low_b, warn, tsd;
  assign {slp_n, en_pin, low_a, low_b, warn, tsd} = filt_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  logic [4:0] ctrl_q;
  logic clr_cmd;
  logic wr_ctrl;
  logic [7:0] status;
  logic hit;
  assign hit = (i_paddr == `MDFS_CTRL_OFS) || (i_paddr == `MDFS_STAT_OFS);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign wr_ctrl = i_psel && i_penable && i_pwrite && (i_paddr == `MDFS_CTRL_OFS);
  assign clr_cmd = wr_ctrl && i_pwdata[`MDFS_CTRL_CLR];
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      ctrl_q <= `MDFS_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= i_pwdata[4:0];
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      o_prdata <= 32'h0000_0000;
    else if (i_psel && !i_penable && !i_pwrite)
    begin
      if (i_paddr == `MDFS_CTRL_OFS)
        o_prdata <= {27'h0, ctrl_q};
      else if (i_paddr == `MDFS_STAT_OFS)
        o_prdata <= {24'h0, status};
      else
        o_prdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep sequencing and sleep reset pulse
  mdfs_pwr_e pwr_q;
  mdfs_cnt_t low_cnt_q;
  logic slp_prev_q;
  logic pulse_clr;
  logic wake;
  assign wake = slp_n && !slp_prev_q && (pwr_q == MDFS_ASLEEP);
  assign pulse_clr = slp_n && !slp_prev_q && (low_cnt_q > 17'(PMIN_CYC))
                     && (low_cnt_q < 17'(PMAX_CYC)); // [R17]
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      pwr_q <= MDFS_AWAKE;
      low_cnt_q <= '0;
      slp_prev_q <= 1'b1;
    end
    else
    begin
      slp_prev_q <= slp_n;
      if (slp_n)
        low_cnt_q <= '0;
      else if (low_cnt_q != 17'h1ffff)
        low_cnt_q <= low_cnt_q + 17'h1;
      unique case (pwr_q)
        MDFS_AWAKE:
          if (!slp_n)
            pwr_q <= MDFS_DOZE;
        MDFS_DOZE:
          if (slp_n)
            pwr_q <= MDFS_AWAKE;
          else if (low_cnt_q >= 17'(SLEEP_CYC - 1))
            pwr_q <= MDFS_ASLEEP; // [R14]
        MDFS_ASLEEP:
          if (slp_n)
            pwr_q <= MDFS_AWAKE; // [R14]
        default:
          pwr_q <= MDFS_AWAKE;
      endcase
    end
  end
  logic clear_all;
  assign clear_all = clr_cmd || pulse_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Open-load timers and flags
  logic [16:0] ola_cnt_q, olb_cnt_q;
  logic ola_det, olb_det;
  logic open_q, ola_q, olb_q;
  function automatic logic [16:0] open_next(input logic low, input logic [16:0] c);
    if (!low || !ctrl_q[`MDFS_CTRL_OPEN_EN])
      open_next = '0;
    else if (c < 17'(OPEN_CYC))
      open_next = c + 17'h1;
    else
      open_next = c;
  endfunction
  assign ola_det = (ola_cnt_q == 17'(OPEN_CYC)); // [R1] [R2]
  assign olb_det = (olb_cnt_q == 17'(OPEN_CYC));
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      ola_cnt_q <= '0;
      olb_cnt_q <= '0;
    end
    else
    begin
      ola_cnt_q <= open_next(low_a, ola_cnt_q); // [R1] [R2]
      olb_cnt_q <= open_next(low_b, olb_cnt_q);
    end
  end
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      open_q <= 1'b0;
      ola_q <= 1'b0;
      olb_q <= 1'b0;
    end
    else
    begin
      open_q <= (ola_det || olb_det) || (open_q && !clear_all && !wake); // [R3] [R6]
      ola_q <= ola_det || (ola_q && !clear_all && !wake); // [R4]
      olb_q <= olb_det || (olb_q && !clear_all && !wake); // [R4]
    end
  end
  logic open_alarm;
  assign open_alarm = ctrl_q[`MDFS_CTRL_OPEN_MODE] ? (ola_det || olb_det) : open_q; // [R5]

  ////////////////////////////////////////////////////////////////////////////
  // Thermal flags and shutdown
  logic therm_q, sdown_q, tsd_hold_q;
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      therm_q <= 1'b0;
      sdown_q <= 1'b0;
      tsd_hold_q <= 1'b0;
    end
    else
    begin
      therm_q <= tsd || (therm_q && !clear_all); // [R10] [R12]
      sdown_q <= tsd || (sdown_q && !clear_all); // [R10] [R12]
      if (tsd)
        tsd_hold_q <= 1'b1; // [R10]
      else if (ctrl_q[`MDFS_CTRL_TSD_MODE])
        tsd_hold_q <= 1'b0; // [R12]
      else if (pulse_clr)
        tsd_hold_q <= 1'b0; // [R11]
    end
  end
  logic therm_flag;
  assign therm_flag = therm_q || warn; // [R7] [R8]
  logic warn_rep;
  assign warn_rep = warn && ctrl_q[`MDFS_CTRL_WARN_REP]; // [R9]

  ////////////////////////////////////////////////////////////////////////////
  // Alarm, error flag and power stage gating
  logic alarm;
  logic err_q;
  assign alarm = open_alarm || warn_rep || tsd_hold_q; // [R18]
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
      err_q <= 1'b0;
    else
      err_q <= ola_det || olb_det || tsd || warn_rep
               || (err_q && !clear_all && !wake && (alarm || open_q || sdown_q)); // [R3] [R10]
  end
  assign status = {pwr_q == MDFS_ASLEEP, sdown_q, therm_flag, warn, olb_q, ola_q, open_q,
                   err_q || alarm};
  logic asleep;
  assign asleep = (pwr_q == MDFS_ASLEEP);
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_b)
    begin
      o_bridge_enable <= 1'b0;
      o_charge_pump_enable <= 1'b0;
      o_logic_regulator_enable <= 1'b0;
      o_serial_enable <= 1'b0;
      o_alarm_out_n_oe <= 1'b0;
    end
    else
    begin
      o_bridge_enable <= slp_n && en_pin && ctrl_q[`MDFS_CTRL_OUT_EN]
                         && !tsd_hold_q && !asleep; // [R13] [R15] [R16] [R10]
      o_charge_pump_enable <= !asleep && !tsd_hold_q; // [R7] [R10] [R13]
      o_logic_regulator_enable <= !asleep; // [R13]
      o_serial_enable <= !asleep; // [R13]
      o_alarm_out_n_oe <= alarm && !asleep; // [R18]
    end
  end
  assign o_alarm_out_n = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_gate;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      o_bridge_enable |-> $past(en_pin) && $past(ctrl_q[`MDFS_CTRL_OUT_EN]);
  endproperty
  a_gate: assert property (p_gate) else $error("bridge enabled without enable"); // [R16]
  property p_open_en;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      !ctrl_q[`MDFS_CTRL_OPEN_EN] |=> !ola_det && !olb_det;
  endproperty
  a_open_en: assert property (p_open_en) else $error("open load while disabled"); // [R2]
  property p_open_latch;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      ola_det |=> open_q && ola_q;
  endproperty
  a_open_latch: assert property (p_open_latch) else $error("open flag not set"); // [R3]
  property p_tsd;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      tsd |=> (sdown_q && tsd_hold_q) ##1 (!o_bridge_enable && !o_charge_pump_enable);
  endproperty
  a_tsd: assert property (p_tsd) else $error("shutdown not taken"); // [R10]
  property p_warn;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      warn && ctrl_q[`MDFS_CTRL_WARN_REP] && !asleep |=> o_alarm_out_n_oe;
  endproperty
  a_warn: assert property (p_warn) else $error("warning not reported"); // [R9]
  property p_sleep;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      asleep |=> !o_logic_regulator_enable && !o_serial_enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not honoured"); // [R13]
  property p_en;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      !en_pin |=> !o_bridge_enable;
  endproperty
  a_en: assert property (p_en) else $error("bridge on with enable low"); // [R15]
  property p_clr;
    @(posedge i_core_clk) disable iff (!i_rst_b)
      clr_cmd && !tsd && !ola_det && !olb_det |=> !sdown_q && !open_q;
  endproperty
  a_clr: assert property (p_clr) else $error("clear ignored"); // [R12]
  c_open: cover property (@(posedge i_core_clk) ola_det);
  c_tsd: cover property (@(posedge i_core_clk) tsd_hold_q ##1 !tsd_hold_q);
  c_pulse: cover property (@(posedge i_core_clk) pulse_clr);
  c_sleep: cover property (@(posedge i_core_clk) asleep);
endmodule
`default_nettype wire

/* tb/mdfs_ctrl_model.sv */
// Model of the motion controller pins and the pulled-up alarm line
`timescale 1ns/1ns
`default_nettype none
module mdfs_ctrl_model (
  // Clock
  input wire logic i_core_clk,
  // Alarm pin of the driver
  input wire logic i_alarm_out_n,
  input wire logic i_alarm_out_n_oe,
  // Controller pins
  output logic o_low_power_request_n,
  output logic o_enable,
  output logic o_alarm_level
);
  localparam int WAKE_CYC = 12;
  ////////////////////////////////////////////////////////////////////////////
  // Pull-up wins whenever the driver lets go of the line
  assign o_alarm_level = i_alarm_out_n_oe ? i_alarm_out_n : 1'b1;
  initial
  begin
    o_low_power_request_n = 1'b1;
    o_enable = 1'b1;
  end
  task automatic set_en(input logic v);
    o_enable <= v;
  endtask
  // Rising the pin is followed by the wake time before new inputs
  task automatic sleep_pin(input logic v);
    o_low_power_request_n <= v;
    @(posedge i_core_clk);
    if (v)
      repeat (WAKE_CYC) @(posedge i_core_clk);
  endtask
  // Fault clear pulse kept inside the accepted low-time window
  task automatic reset_pulse();
    sleep_pin(1'b0);
    repeat (6) @(posedge i_core_clk);
    sleep_pin(1'b1);
  endtask
endmodule
`default_nettype wire

/* tb/mdfs_supervisor_bench.sv */
// Self-checking bench of the motor driver fault supervisor
`timescale 1ns/1ns
`default_nettype none
`include "mdfs_map.svh"
module mdfs_supervisor_bench;
  import mdfs_pkg::*;
  localparam int OLC = 20;
  localparam int SLC = 50;
  logic clk, rst_b, psel, pen, pwr, pready, serr, pslverr, wa, wb, warn, sdn;
  logic slp_n, en, br, cp, reg_en, ser, al_n, al_oe, alarm, e, o;
  logic [11:0] paddr;
  mdfs_word_t pwdata, prdata, rd;
  int err_total, tests_run;
  mdfs_supervisor #(.OPEN_CYC(OLC), .SLEEP_CYC(SLC), .PMIN_CYC(5), .PMAX_CYC(10)) i_dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .i_low_power_request_n(slp_n), .i_enable(en), .i_wind_a_low(wa),
    .i_wind_b_low(wb), .i_warn_temperature(warn), .i_shutdown_temperature(sdn),
    .o_bridge_enable(br), .o_charge_pump_enable(cp), .o_logic_regulator_enable(reg_en),
    .o_serial_enable(ser), .o_alarm_out_n(al_n), .o_alarm_out_n_oe(al_oe));
  mdfs_ctrl_model i_ctl (.i_core_clk(clk), .i_alarm_out_n(al_n), .i_alarm_out_n_oe(al_oe),
    .o_low_power_request_n(slp_n), .o_enable(en), .o_alarm_level(alarm));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input mdfs_word_t d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wctl(input logic [5:0] v);
    apb(1'b1, `MDFS_CTRL_OFS, {26'h0, v});
  endtask
  // Expected status word from the individual fault bits
  function automatic mdfs_word_t st(input logic er, ola, olb, wn, th, sd);
    return {24'h0, 1'b0, sd, th, wn, olb, ola, ola | olb, er};
  endfunction
  task automatic rstat(input string what, input mdfs_word_t exp);
    apb(1'b0, `MDFS_STAT_OFS, '0);
    chk(what, rd, exp);
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #80000;
    err_total++;
    final_report;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {psel, pen, pwr, paddr, pwdata, wa, wb, warn, sdn} = '0;
    {err_total, tests_run} = '0;
    rst_b = 1'b0;
    void'($urandom(32'he6be2569));
    cyc(20);
    rst_b <= 1'b1;
    cyc(1);
    apb(1'b0, `MDFS_CTRL_OFS, '0);
    chk("ctrl_reset", rd, 0);
    rstat("stat_reset", 0);
    chk("alarm_idle", alarm, 1);
    apb(1'b0, 12'h008, '0);
    chk("unmapped_err", serr, 1);
    chk("unmapped_data", rd, 0);
    $display("Test reset done");
    for (int i = 0; i < 14; i++)
    begin
      e = (i > 11) | 1'($urandom);
      o = (i > 11) | 1'($urandom);
      i_ctl.set_en(e);
      wctl({1'b0, o, 4'h0});
      cyc(10);
      chk("bridge_gate", br, e & o);
    end
    $display("Test gating done");
    wa <= 1'b1;
    cyc(OLC + 20);
    rstat("ol_disabled", 0);
    wa <= 1'b0;
    wctl(6'h11);
    wa <= 1'b1;
    cyc(OLC - 8);
    chk("ol_early", alarm, 1);
    cyc(20);
    chk("ol_alarm", alarm, 0);
    chk("ol_bridge", br, 1);
    rstat("ol_a_stat", st(1, 1, 0, 0, 0, 0));
    wa <= 1'b0;
    cyc(10);
    chk("ol_mode0_hold", alarm, 0);
    wctl(6'h31);
    cyc(5);
    chk("ol_mode0_clear", alarm, 1);
    rstat("ol_cleared", 0);
    wctl(6'h13);
    wb <= 1'b1;
    cyc(OLC + 20);
    rstat("ol_b_stat", st(1, 0, 1, 0, 0, 0));
    wb <= 1'b0;
    cyc(10);
    chk("ol_mode1_release", alarm, 1);
    wctl(6'h31);
    wctl(6'h11);
    wb <= 1'b1;
    cyc(OLC + 20);
    wb <= 1'b0;
    i_ctl.sleep_pin(1'b0);
    cyc(SLC / 2);
    chk("sleep_delay_pump", cp, 1);
    chk("sleep_pin_bridge", br, 0);
    cyc(SLC);
    chk("asleep_outputs", {br, cp, reg_en, ser}, 0);
    i_ctl.sleep_pin(1'b1);
    chk("wake_regulator", reg_en, 1);
    rstat("wake_clears_ol", 0);
    $display("Test open load and sleep done");
    wctl(6'h10);
    warn <= 1'b1;
    cyc(10);
    rstat("warn_stat", st(0, 0, 0, 1, 1, 0));
    chk("warn_run", {alarm, br, cp}, 3'h7);
    wctl(6'h14);
    cyc(5);
    rstat("warn_rep_stat", st(1, 0, 0, 1, 1, 0));
    chk("warn_rep_alarm", alarm, 0);
    warn <= 1'b0;
    cyc(10);
    rstat("warn_cooled", 0);
    chk("warn_cooled_alarm", alarm, 1);
    $display("Test warning done");
    for (int m = 0; m < 2; m++)
    begin
      wctl({2'b01, m[0], 3'h0});
      sdn <= 1'b1;
      cyc(10);
      chk("tsd_off", {br, cp, alarm}, 0);
      rstat("tsd_stat", st(1, 0, 0, 0, 1, 1));
      sdn <= 1'b0;
      cyc(10);
      chk("tsd_cooled", {br, alarm}, {m[0], m[0]});
      if (m == 0)
      begin
        i_ctl.sleep_pin(1'b0);
        cyc(1);
        i_ctl.sleep_pin(1'b1);
        chk("tsd_short_pulse", br, 0);
        i_ctl.reset_pulse();
      end
      else
        rstat("tsd_kept", st(1, 0, 0, 0, 1, 1));
      wctl({2'h3, m[0], 3'h0});
      cyc(3);
      chk("tsd_resumed", {br, cp, alarm}, 3'h7);
      rstat("tsd_clear", 0);
    end
    $display("Test shutdown done");
    final_report;
  end
endmodule
`default_nettype wire
